// >>> hw/drive_consts.svh
/*
 Constants for the drive state control block: object indices, command
 and status bit positions, quick stop behaviour codes.
 Assumes inclusion by bare name from the design files.
*/
`ifndef DRIVE_CONSTS_SVH
`define DRIVE_CONSTS_SVH

`define IDX_COMMAND     16'h6040
`define IDX_STATUS      16'h6041

`define CMD_SWITCH_ON   0
`define CMD_EN_VOLTAGE  1
`define CMD_QSTOP_N     2
`define CMD_EN_OP       3
`define CMD_MODE_LO     4
`define CMD_MODE_HI     6
`define CMD_FAULT_RST   7
`define CMD_HALT        8
`define CMD_USED_MASK   16'h01ff

`define ST_READY        0
`define ST_SWITCHED_ON  1
`define ST_OP_ENABLED   2
`define ST_FAULT        3
`define ST_VOLTAGE      4
`define ST_QSTOP_N      5
`define ST_SW_DISABLED  6
`define ST_WARNING      7
`define ST_ABORTED      8

`define QS_STAY         3'h5
`define QS_RESUME_MIN   3'h5
`define QS_RESUME_MAX   4'h8

`endif

// >>> hw/drive_pkg.sv
/*
 Types for the drive state control block.
 Assumes drive_consts.svh is compiled alongside.
*/
package drive_pkg;
  typedef enum logic [2:0] {
    S_NOT_READY   = 3'h0,
    S_SW_DISABLED = 3'h1,
    S_READY       = 3'h2,
    S_SWITCHED_ON = 3'h3,
    S_OP_ENABLED  = 3'h4,
    S_QSTOP       = 3'h5,
    S_FAULT_REACT = 3'h6,
    S_FAULT       = 3'h7
  } drive_state_t;
endpackage : drive_pkg

// >>> hw/command_decode.sv
/*
 Decodes the command word into drive commands and catches the
 fault reset rising edge.
 Assumes the command word is registered by the caller.
*/
`timescale 1ns/100ps
`include "drive_consts.svh"

module command_decode (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [15:0] cmd,
  output logic             shutdown,
  output logic             switch_on,
  output logic             enable_op,
  output logic             disable_voltage,
  output logic             quick_stop,
  output logic             fault_rst_edge
);
  logic fault_rst_reg;
  logic fault_rst_next;

  always_comb begin
    fault_rst_next  = cmd[`CMD_FAULT_RST];
    disable_voltage = !cmd[`CMD_EN_VOLTAGE];
    quick_stop      = cmd[`CMD_EN_VOLTAGE] && !cmd[`CMD_QSTOP_N]; // [RQ5]
    shutdown        = cmd[`CMD_EN_VOLTAGE] && cmd[`CMD_QSTOP_N] &&
                      !cmd[`CMD_SWITCH_ON];
    switch_on       = cmd[`CMD_EN_VOLTAGE] && cmd[`CMD_QSTOP_N] &&
                      cmd[`CMD_SWITCH_ON];
    // All three enable bits together, quick stop not requested
    enable_op       = switch_on && cmd[`CMD_EN_OP]; // [RQ4]
    // Edge only: a held bit never retries the clear
    fault_rst_edge  = cmd[`CMD_FAULT_RST] && !fault_rst_reg; // [RQ7]
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_rst_reg <= 1'b0;
    end else begin
      fault_rst_reg <= fault_rst_next;
    end
  end
endmodule : command_decode

// >>> hw/drive_control.sv
/*
 Drive state control: command word register, state machine and status
 word. The host writes the command word through cmd_wr/cmd_wdata.
 Assumes fault, warning, bus voltage and trajectory events come in
 synchronous to clk from the power stage and trajectory logic.
*/
`timescale 1ns/100ps
`include "drive_consts.svh"

// How it works
// RQ1 - Enable-operation in quick stop resumes operation when code is 5 to 8
// RQ2 - Host clears fault reset bit itself after leaving fault
// RQ3 - Sixteen-bit read/write command word controls state, output and moves
// RQ4 - Drive enables only with switch on, enable voltage, enable operation; code also raises drive_enable in S_FAULT_REACT from any state but S_FAULT
// RQ5 - Command bit 2 low requests a quick stop
// RQ6 - Command bits 4 to 6 go out to the active operating mode
// RQ7 - Fault clear attempted only on rising edge of bit 7
// RQ8 - Command bit 8 high halts current motion
// RQ9 - Sixteen-bit read-only status word reflects the drive state
// RQ10 - Status bits 0,1,2,6 flag ready, switched on, enabled, disabled
// RQ11 - Status bit 3 shows a latched fault
// RQ12 - Status bit 4 shows bus voltage above minimum
// RQ13 - Status bit 5 reads zero during quick stop
// RQ14 - Status bit 7 shows any warning present
// RQ15 - Status bit 8 set on aborted trajectory, clear on normal finish
// RQ16 - Fault reset in fault enters switch-on-disabled if no fault remains
// RQ17 - Quick stop done or disable voltage leaves quick stop unless code 5
// RQ18 - Reserved command bits 9 to 15 ignored and read as zero
module drive_control (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        cmd_wr,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic [2:0]  qstop_code,
  input  wire logic        init_done,
  input  wire logic        fault_active,
  input  wire logic        fault_react_done,
  input  wire logic        qstop_done,
  input  wire logic        bus_voltage_ok,
  input  wire logic        warning_active,
  input  wire logic        traj_aborted,
  input  wire logic        traj_finished,
  output logic [15:0]      command_word,
  output logic [15:0]      status_word,
  output logic             power_on,
  output logic             drive_enable,
  output logic             qstop_run,
  output logic             halt,
  output logic [2:0]       mode_bits
);
  drive_pkg::drive_state_t state_reg;
  drive_pkg::drive_state_t state_next;
  logic [15:0] cmd_reg;
  logic [15:0] cmd_next;
  logic        fault_latch_reg;
  logic        fault_latch_next;
  logic        aborted_reg;
  logic        aborted_next;
  logic [15:0] status_next;
  logic        power_next;
  logic        enable_next;
  logic        qs_run_next;
  logic        c_shutdown;
  logic        c_switch_on;
  logic        c_enable_op;
  logic        c_dis_volt;
  logic        c_qstop;
  logic        c_fault_edge;

  function automatic logic qs_resumable(input logic [2:0] code);
    qs_resumable = (code >= `QS_RESUME_MIN) &&
                   ({1'b0, code} <= `QS_RESUME_MAX);
  endfunction : qs_resumable

  command_decode u_decode (
    .clk             (clk),
    .nrst            (nrst),
    .cmd             (cmd_reg),
    .shutdown        (c_shutdown),
    .switch_on       (c_switch_on),
    .enable_op       (c_enable_op),
    .disable_voltage (c_dis_volt),
    .quick_stop      (c_qstop),
    .fault_rst_edge  (c_fault_edge)
  );

  always_comb begin
    // Reserved bits never stored
    cmd_next = cmd_wr ? (cmd_wdata & `CMD_USED_MASK) : cmd_reg; // [RQ3] [RQ18]
    // Fault input latches; clear only by an edge with fault gone
    fault_latch_next = fault_latch_reg;
    if (fault_active) begin
      fault_latch_next = 1'b1;
    end else if (state_reg == drive_pkg::S_FAULT && c_fault_edge) begin
      fault_latch_next = 1'b0; // [RQ16]
    end
    aborted_next = aborted_reg;
    if (traj_aborted) begin
      aborted_next = 1'b1; // [RQ15]
    end else if (traj_finished) begin
      aborted_next = 1'b0; // [RQ15]
    end
    state_next = state_reg;
    case (state_reg)
      drive_pkg::S_NOT_READY: begin
        if (init_done) state_next = drive_pkg::S_SW_DISABLED;
      end
      drive_pkg::S_SW_DISABLED: begin
        if (c_shutdown) state_next = drive_pkg::S_READY;
      end
      drive_pkg::S_READY: begin
        if (c_dis_volt || c_qstop) state_next = drive_pkg::S_SW_DISABLED;
        else if (c_switch_on) state_next = drive_pkg::S_SWITCHED_ON;
      end
      drive_pkg::S_SWITCHED_ON: begin
        if (c_dis_volt || c_qstop) state_next = drive_pkg::S_SW_DISABLED;
        else if (c_shutdown) state_next = drive_pkg::S_READY;
        else if (c_enable_op) state_next = drive_pkg::S_OP_ENABLED; // [RQ4]
      end
      drive_pkg::S_OP_ENABLED: begin
        if (c_dis_volt) state_next = drive_pkg::S_SW_DISABLED;
        else if (c_qstop) state_next = drive_pkg::S_QSTOP;
        else if (c_shutdown) state_next = drive_pkg::S_READY;
        else if (!c_enable_op) state_next = drive_pkg::S_SWITCHED_ON;
      end
      drive_pkg::S_QSTOP: begin
        if ((qstop_done || c_dis_volt) && qstop_code != `QS_STAY) begin
          state_next = drive_pkg::S_SW_DISABLED; // [RQ17]
        end else if (c_enable_op && qs_resumable(qstop_code)) begin
          state_next = drive_pkg::S_OP_ENABLED; // [RQ1]
        end
      end
      drive_pkg::S_FAULT_REACT: begin
        if (fault_react_done) state_next = drive_pkg::S_FAULT;
      end
      drive_pkg::S_FAULT: begin
        // Host must drop bit 7 before the next attempt [RQ2]
        if (c_fault_edge && !fault_active) begin
          state_next = drive_pkg::S_SW_DISABLED; // [RQ16]
        end
      end
      default: state_next = drive_pkg::S_NOT_READY;
    endcase
    // A new fault overrides any command
    if (fault_active && state_reg != drive_pkg::S_FAULT &&
        state_reg != drive_pkg::S_FAULT_REACT) begin
      state_next = drive_pkg::S_FAULT_REACT;
    end
    power_next  = state_next == drive_pkg::S_SWITCHED_ON ||
                  state_next == drive_pkg::S_OP_ENABLED ||
                  state_next == drive_pkg::S_QSTOP ||
                  state_next == drive_pkg::S_FAULT_REACT;
    enable_next = state_next == drive_pkg::S_OP_ENABLED ||
                  state_next == drive_pkg::S_QSTOP ||
                  state_next == drive_pkg::S_FAULT_REACT;
    qs_run_next = state_next == drive_pkg::S_QSTOP ||
                  state_next == drive_pkg::S_FAULT_REACT;
    status_next = 16'h0000;
    status_next[`ST_READY]       = state_next == drive_pkg::S_READY ||
                                   power_next; // [RQ10]
    status_next[`ST_SWITCHED_ON] = power_next; // [RQ10]
    status_next[`ST_OP_ENABLED]  = enable_next; // [RQ10]
    status_next[`ST_FAULT]       = fault_latch_next ||
                                   state_next == drive_pkg::S_FAULT; // [RQ11]
    status_next[`ST_VOLTAGE]     = bus_voltage_ok; // [RQ12]
    status_next[`ST_QSTOP_N]     = state_next != drive_pkg::S_QSTOP; // [RQ13]
    status_next[`ST_SW_DISABLED] = state_next ==
                                   drive_pkg::S_SW_DISABLED; // [RQ10]
    status_next[`ST_WARNING]     = warning_active; // [RQ14]
    status_next[`ST_ABORTED]     = aborted_next; // [RQ15] [RQ9]
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg       <= drive_pkg::S_NOT_READY;
      cmd_reg         <= 16'h0000;
      fault_latch_reg <= 1'b0;
      aborted_reg     <= 1'b0;
      command_word    <= 16'h0000;
      status_word     <= 16'h0000;
      power_on        <= 1'b0;
      drive_enable    <= 1'b0;
      qstop_run       <= 1'b0;
      halt            <= 1'b0;
      mode_bits       <= 3'h0;
    end else begin
      state_reg       <= state_next;
      cmd_reg         <= cmd_next;
      fault_latch_reg <= fault_latch_next;
      aborted_reg     <= aborted_next;
      command_word    <= cmd_next;
      status_word     <= status_next;
      power_on        <= power_next;
      drive_enable    <= enable_next;
      qstop_run       <= qs_run_next;
      halt            <= cmd_next[`CMD_HALT]; // [RQ8]
      mode_bits       <= cmd_next[`CMD_MODE_HI:`CMD_MODE_LO]; // [RQ6]
    end
  end

  property p_resume;
    @(posedge clk) disable iff (!nrst)
    (state_reg == drive_pkg::S_QSTOP && c_enable_op && !fault_active &&
     !qstop_done && qs_resumable(qstop_code)) |=>
    drive_enable && !qstop_run;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume"); // [RQ1]

  property p_rsvd;
    @(posedge clk) disable iff (!nrst)
    command_word[15:9] == 7'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set"); // [RQ18]

  property p_enable;
    @(posedge clk) disable iff (!nrst)
    $rose(drive_enable) && !qstop_run |-> $past(c_enable_op);
  endproperty
  a_enable: assert property (p_enable) else $error("bad enable"); // [RQ4]

  property p_qs_bit;
    @(posedge clk) disable iff (!nrst)
    // Status holds its reset zero for one edge after release
    $past(nrst) |-> status_word[`ST_QSTOP_N] ==
    !(qstop_run && !status_word[`ST_FAULT]);
  endproperty
  a_qs_bit: assert property (p_qs_bit) else $error("qs bit"); // [RQ13]

  property p_fault_clear;
    @(posedge clk) disable iff (!nrst)
    (state_reg == drive_pkg::S_FAULT && cmd_reg[`CMD_FAULT_RST] &&
     $past(cmd_reg[`CMD_FAULT_RST])) |=> state_reg == drive_pkg::S_FAULT;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("retry"); // [RQ7]

  property p_stay;
    @(posedge clk) disable iff (!nrst)
    (state_reg == drive_pkg::S_QSTOP && qstop_code == `QS_STAY &&
     !fault_active) |=> state_reg != drive_pkg::S_SW_DISABLED;
  endproperty
  a_stay: assert property (p_stay) else $error("left qs at 5"); // [RQ17]

  property p_halt;
    @(posedge clk) disable iff (!nrst)
    cmd_wr |=> halt == $past(cmd_wdata[`CMD_HALT]);
  endproperty
  a_halt: assert property (p_halt) else $error("halt"); // [RQ8]

  property p_warn;
    @(posedge clk) disable iff (!nrst)
    warning_active |=> status_word[`ST_WARNING];
  endproperty
  a_warn: assert property (p_warn) else $error("warning"); // [RQ14]
endmodule : drive_control

// >>> sim/host_model.sv
/*
 Network host model: writes the drive command word one word at a time.
 Assumes the bench calls its tasks and that clk is the drive clock.
*/
`timescale 1ns/100ps
module host_model (
  input  wire logic        clk,
  output logic             cmd_wr,
  output logic [15:0]      cmd_wdata
);
  initial begin
    cmd_wr    = 1'b0;
    cmd_wdata = 16'h0000;
  end

  task automatic send(input logic [15:0] w);
    @(negedge clk);
    cmd_wr    = 1'b1;
    cmd_wdata = w;
    @(negedge clk);
    cmd_wr    = 1'b0;
    // Released data is inverted so stale values are never trusted
    cmd_wdata = ~w;
  endtask : send
endmodule : host_model

// >>> sim/drive_command_status_words_tb.sv
/*
 Self-checking bench for the drive state control block.
 Assumes a 50 MHz clock and the host model as the command source.
*/
`timescale 1ns/100ps
module drive_command_status_words_tb;
  logic        clk, nrst, cmd_wr, init_done, fault_active;
  logic        fault_react_done, qstop_done, bus_voltage_ok;
  logic        warning_active, traj_aborted, traj_finished, ab;
  logic        power_on, drive_enable, qstop_run, halt;
  logic [15:0] cmd_wdata, command_word, status_word;
  logic [2:0]  qstop_code, mode_bits;
  logic [31:0] lfsr;
  int          bad_count, compares;

  host_model host (.clk(clk), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata));
  drive_control DUT (.clk, .nrst, .cmd_wr, .cmd_wdata, .qstop_code,
    .init_done, .fault_active, .fault_react_done, .qstop_done,
    .bus_voltage_ok, .warning_active, .traj_aborted, .traj_finished,
    .command_word, .status_word, .power_on, .drive_enable, .qstop_run,
    .halt, .mode_bits);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : step

  function automatic logic [15:0] exp_st(input drive_pkg::drive_state_t s);
    logic [15:0] b;
    case (s)
      drive_pkg::S_SW_DISABLED: b = 16'h0060;
      drive_pkg::S_READY:       b = 16'h0021;
      drive_pkg::S_SWITCHED_ON: b = 16'h0023;
      drive_pkg::S_OP_ENABLED:  b = 16'h0027;
      drive_pkg::S_QSTOP:       b = 16'h0007;
      drive_pkg::S_FAULT:       b = 16'h0028;
      default:                  b = 16'h0020;
    endcase
    return b | {7'h00, ab, warning_active, 2'h0, bus_voltage_ok, 4'h0};
  endfunction : exp_st

  task automatic check(input string n, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic cmd(input logic [15:0] w);
    lfsr = step(lfsr);
    w = w | (lfsr[15:0] & 16'hff70);
    host.send(w);
    check("command_word", command_word, w & 16'h01ff);
    check("halt", {15'h0000, halt}, {15'h0000, w[8]});
    check("mode_bits", {13'h0000, mode_bits}, {13'h0000, w[6:4]});
    repeat (2) @(negedge clk);
  endtask : cmd

  task automatic st(input drive_pkg::drive_state_t s);
    check("status_word", status_word, exp_st(s));
    check("power_on", {15'h0000, power_on}, {15'h0000, s inside
      {drive_pkg::S_SWITCHED_ON, drive_pkg::S_OP_ENABLED,
       drive_pkg::S_QSTOP}});
    check("drive_enable", {15'h0000, drive_enable}, {15'h0000, s inside
      {drive_pkg::S_OP_ENABLED, drive_pkg::S_QSTOP}});
    check("qstop_run", {15'h0000, qstop_run},
          {15'h0000, s == drive_pkg::S_QSTOP});
  endtask : st

  task automatic to_op();
    cmd(16'h0006);
    st(drive_pkg::S_READY);
    cmd(16'h0007);
    st(drive_pkg::S_SWITCHED_ON);
    cmd(16'h000f);
    st(drive_pkg::S_OP_ENABLED);
  endtask : to_op

  task automatic end_of_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Whole run is under five hundred cycles; this leaves a wide margin
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    nrst = 1'b0; init_done = 1'b0; fault_active = 1'b0;
    fault_react_done = 1'b0; qstop_done = 1'b0; bus_voltage_ok = 1'b1;
    warning_active = 1'b0; traj_aborted = 1'b0; traj_finished = 1'b0;
    qstop_code = 3'h0; ab = 1'b0; lfsr = 32'h00014c03;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    st(drive_pkg::S_NOT_READY);
    init_done = 1'b1;
    repeat (3) @(negedge clk);
    st(drive_pkg::S_SW_DISABLED);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      to_op();
      lfsr = step(lfsr);
      bus_voltage_ok = lfsr[0];
      warning_active = lfsr[1];
      traj_aborted = lfsr[2];
      traj_finished = lfsr[3];
      ab = lfsr[2] | (ab & ~lfsr[3]);
      @(negedge clk);
      traj_aborted = 1'b0;
      traj_finished = 1'b0;
      repeat (2) @(negedge clk);
      st(drive_pkg::S_OP_ENABLED);
      bus_voltage_ok = 1'b1;
      cmd(16'h0007);
      cmd(16'h000e);
      st(drive_pkg::S_READY);
      cmd(16'h0000);
      st(drive_pkg::S_SW_DISABLED);
    end
    to_op();
    cmd(16'h0000);
    st(drive_pkg::S_SW_DISABLED);
    cmd(16'h0006);
    cmd(16'h000b);
    st(drive_pkg::S_SW_DISABLED);
    cmd(16'h0006);
    cmd(16'h0007);
    cmd(16'h0006);
    st(drive_pkg::S_READY);
    cmd(16'h0007);
    cmd(16'h0002);
    st(drive_pkg::S_SW_DISABLED);
    $display("test walk done");
    for (int c = 0; c < 8; c++) begin
      qstop_code = c[2:0];
      to_op();
      cmd(16'h000b);
      st(drive_pkg::S_QSTOP);
      cmd(16'h000f);
      st(c >= 5 ? drive_pkg::S_OP_ENABLED : drive_pkg::S_QSTOP);
      if (c < 5) begin
        qstop_done = 1'b1;
        @(negedge clk);
        qstop_done = 1'b0;
        repeat (2) @(negedge clk);
        st(drive_pkg::S_SW_DISABLED);
      end else begin
        cmd(16'h000b);
        cmd(16'h0000);
        st(c == 5 ? drive_pkg::S_QSTOP : drive_pkg::S_SW_DISABLED);
        if (c == 5) cmd(16'h000f);
      end
    end
    $display("test quick stop done");
    qstop_code = 3'h2;
    to_op();
    fault_active = 1'b1;
    repeat (3) @(negedge clk);
    check("fault_bit", {15'h0000, status_word[3]}, 16'h0001);
    fault_react_done = 1'b1;
    @(negedge clk);
    fault_react_done = 1'b0;
    repeat (2) @(negedge clk);
    st(drive_pkg::S_FAULT);
    cmd(16'h0080);
    st(drive_pkg::S_FAULT);
    fault_active = 1'b0;
    cmd(16'h0080);
    st(drive_pkg::S_FAULT);
    cmd(16'h0000);
    cmd(16'h0080);
    st(drive_pkg::S_SW_DISABLED);
    cmd(16'h0000);
    st(drive_pkg::S_SW_DISABLED);
    $display("test fault done");
    end_of_test();
  end
endmodule : drive_command_status_words_tb
